// ==== src/pbm_pkg.sv ====
package pbm_pkg;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    localparam int REG_ADDR_W = 4;
    localparam int REG_DATA_W = 8;
    localparam logic [3:0] REG_PORTB_DATA = 4'h0;
    localparam logic [3:0] REG_PORTB_DIR = 4'h1;
    localparam logic [3:0] REG_PORTB_PINS = 4'h2;
    localparam logic [3:0] REG_PORTC_DATA = 4'h3;
    localparam logic [3:0] REG_PORTC_DIR = 4'h4;
    localparam logic [3:0] REG_PORTC_PINS = 4'h5;
    localparam logic [3:0] REG_CONTROL = 4'h6;
    localparam int CTRL_PULLUP_DISABLE_BIT = 0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_PORT_DATA = 8'h00;
    localparam logic [7:0] RST_PORT_DIR = 8'h00;
    localparam logic RST_PULLUP_DISABLE = 1'b0;
    localparam logic [15:0] RST_PIN_OE_N = 16'hFFFF;
    localparam logic [15:0] RST_PIN_ZERO = 16'h0000;

    // ----------------------------------------------------------------
    // Pin positions in the joined 16-bit pin vector
    // ----------------------------------------------------------------
    localparam int PIN_COUNT = 16;
    localparam int PORT_WIDTH = 8;
    localparam int PB0 = 0;
    localparam int PB1 = 1;
    localparam int PB2 = 2;
    localparam int PB3 = 3;
    localparam int PB4 = 4;
    localparam int PB5 = 5;
    localparam int PB6 = 6;
    localparam int PB7 = 7;
    localparam int PC0 = 8;
    localparam int PC1 = 9;
    localparam int PC2 = 10;
    localparam int PC3 = 11;
    localparam int PC4 = 12;
    localparam int PC5 = 13;
    localparam int PC6 = 14;
    localparam int PC7 = 15;

endpackage

// ==== src/pbm_pin_mux.sv ====
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
// Overview of operation
// - Serial slave forces port B bit 1 to input, used as slave data in.
// - Serial master: port B bit 1 direction follows its direction bit.
// - Forced-input port B bit 1 pull-up follows its data bit and disable.
// - Serial master forces port B bit 0 to input, used as master data in.
// - Serial slave: port B bit 0 direction follows its direction bit.
// - Forced-input port B bit 0 pull-up follows its data bit and disable.
// - Serial inputs are pin value gated by location select and reset.
// - Port B bit 7 drives pwm0 output 1 or serial clock.
// - Serial clock input is port B bit 7 gated by select and reset.
// - Pwm2 output 3 enable makes port C bit 3 drive that output.
// - Pwm2 output 2 enable makes port C bit 2 drive that output.
// - Pwm1 output 0 enable makes port C bit 0 drive that output.
// - Interrupt 3 enable forces port C bit 0 input on, routed out.
// - Interrupt 2 forces port B bit 5 input on; disable bit alone off.
// - Interrupt 1 forces port B bit 2 input on; disable bit alone off.
// - Converter output enable turns port C bit 7 driver and input off.
// - Channel digital-disable bits turn the pin's digital input off.
// - Amplifier 0 disable turns off inputs of port B bits 4 and 3.
// - Compare B enable drives port C bit 1; driver follows direction.
// - Port C bits 3 and 2 feed timer 1 and timer 0 count inputs.
// - Port C bit 1 pin feeds the pwm1 digital input.
// - Driver override enable selects driver override value for driver.
// - Value override enable with driver on drives value override.
// - Pull-up follows override, else on when dir,out,disable = 010.
// - Input override selects input enable; otherwise awake state.
module pbm_pin_mux #(
    parameter int PORT_BITS = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [pbm_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [pbm_pkg::REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [pbm_pkg::REG_DATA_W-1:0] reg_rdata,
    input wire logic [pbm_pkg::PIN_COUNT-1:0] pin_in,
    output logic [pbm_pkg::PIN_COUNT-1:0] pin_out,
    output logic [pbm_pkg::PIN_COUNT-1:0] pin_oe_n,
    output logic [pbm_pkg::PIN_COUNT-1:0] pin_pullup_en,
    output logic [pbm_pkg::PIN_COUNT-1:0] pin_input_en,
    input wire logic mcu_sleep,
    input wire logic internal_reset,
    input wire logic serial_if_enable,
    input wire logic serial_if_master_sel,
    input wire logic serial_pin_location_sel,
    input wire logic serial_clock_out,
    input wire logic serial_mosi_out,
    input wire logic serial_miso_out,
    input wire logic pwm0_out1_enable,
    input wire logic pwm0_out1_value,
    input wire logic pwm1_out1_enable,
    input wire logic pwm1_out1_value,
    input wire logic pwm1_out0_enable,
    input wire logic pwm1_out0_value,
    input wire logic pwm2_out2_enable,
    input wire logic pwm2_out2_value,
    input wire logic pwm2_out3_enable,
    input wire logic pwm2_out3_value,
    input wire logic ext_irq1_enable,
    input wire logic ext_irq2_enable,
    input wire logic ext_irq3_enable,
    input wire logic chan4_digital_disable,
    input wire logic chan5_digital_disable,
    input wire logic chan6_digital_disable,
    input wire logic chan7_digital_disable,
    input wire logic chan8_digital_disable,
    input wire logic chan9_digital_disable,
    input wire logic chan10_digital_disable,
    input wire logic amp0_digital_disable,
    input wire logic dac_output_enable,
    input wire logic timer1_cmpb_out_enable,
    input wire logic timer1_cmpb_output,
    output logic serial_clock_pin_in,
    output logic serial_master_data_in,
    output logic serial_slave_data_in,
    output logic ext_irq1_input,
    output logic ext_irq2_input,
    output logic ext_irq3_input,
    output logic timer0_count_input,
    output logic timer1_count_input,
    output logic timer1_capture_b_input,
    output logic pwm1_digital_input,
    output logic global_pullup_disable
);
    import pbm_pkg::*;

    if (PORT_BITS != PORT_WIDTH) begin : g_bad_width
        $error("pbm_pin_mux serves only 8-bit ports");
    end

    // ----------------------------------------------------------------
    // Port registers
    // ----------------------------------------------------------------
    logic [PIN_COUNT-1:0] port_data;
    logic [PIN_COUNT-1:0] port_dir;
    logic [PIN_COUNT-1:0] next_port_data;
    logic [PIN_COUNT-1:0] next_port_dir;
    logic next_pud;

    always_comb begin
        next_port_data = port_data;
        next_port_dir = port_dir;
        next_pud = global_pullup_disable;
        if (reg_write) begin
            unique case (reg_addr)
                REG_PORTB_DATA: next_port_data[PB7:PB0] = reg_wdata;
                REG_PORTB_DIR: next_port_dir[PB7:PB0] = reg_wdata;
                REG_PORTC_DATA: next_port_data[PC7:PC0] = reg_wdata;
                REG_PORTC_DIR: next_port_dir[PC7:PC0] = reg_wdata;
                REG_CONTROL: next_pud = reg_wdata[CTRL_PULLUP_DISABLE_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            port_data <= {RST_PORT_DATA, RST_PORT_DATA};
            port_dir <= {RST_PORT_DIR, RST_PORT_DIR};
            global_pullup_disable <= RST_PULLUP_DISABLE;
        end else begin
            port_data <= next_port_data;
            port_dir <= next_port_dir;
            global_pullup_disable <= next_pud;
        end
    end

    // Read data stand only in the cycle after the strobe; unmapped reads 0
    always_ff @(posedge ref_clk) begin
        if (reset || !reg_read) begin
            reg_rdata <= '0;
        end else begin
            unique case (reg_addr)
                REG_PORTB_DATA: reg_rdata <= port_data[PB7:PB0];
                REG_PORTB_DIR: reg_rdata <= port_dir[PB7:PB0];
                REG_PORTB_PINS: reg_rdata <= pin_in[PB7:PB0]
                    & pin_input_en[PB7:PB0];
                REG_PORTC_DATA: reg_rdata <= port_data[PC7:PC0];
                REG_PORTC_DIR: reg_rdata <= port_dir[PC7:PC0];
                REG_PORTC_PINS: reg_rdata <= pin_in[PC7:PC0]
                    & pin_input_en[PC7:PC0];
                REG_CONTROL: reg_rdata <= {7'h00, global_pullup_disable};
                default: reg_rdata <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Override terms
    // ----------------------------------------------------------------
    // Built from next register values so the pins move on the same edge
    // as the port registers themselves.
    logic spi_on;
    logic spi_master;
    logic spi_slave;
    logic [PIN_COUNT-1:0] pullup_override_en;
    logic [PIN_COUNT-1:0] pullup_override_val;
    logic [PIN_COUNT-1:0] driver_override_en;
    logic [PIN_COUNT-1:0] driver_override_val;
    logic [PIN_COUNT-1:0] value_override_en;
    logic [PIN_COUNT-1:0] value_override_val;
    logic [PIN_COUNT-1:0] input_en_override_en;
    logic [PIN_COUNT-1:0] input_en_override_val;

    assign spi_on = serial_if_enable && serial_pin_location_sel;
    assign spi_master = spi_on && serial_if_master_sel;
    assign spi_slave = spi_on && !serial_if_master_sel;

    always_comb begin
        pullup_override_en = '0;
        pullup_override_val = '0;
        driver_override_en = '0;
        driver_override_val = '0;
        value_override_en = '0;
        value_override_val = '0;
        input_en_override_en = '0;
        input_en_override_val = '0;
        // Bit 7 of port B: serial clock input in slave mode, serial clock out in master mode, else pwm0 output 1
        pullup_override_en[PB7] = spi_slave;
        pullup_override_val[PB7] = next_port_data[PB7] && !next_pud;
        driver_override_en[PB7] = spi_slave || pwm0_out1_enable;
        driver_override_val[PB7] = pwm0_out1_enable && !spi_slave;
        value_override_en[PB7] = spi_master || pwm0_out1_enable;
        value_override_val[PB7] = spi_master ? serial_clock_out
                                             : pwm0_out1_value;
        input_en_override_en[PB7] = chan4_digital_disable;
        // Bit 6 of port B: pwm1 output 1
        driver_override_en[PB6] = pwm1_out1_enable;
        driver_override_val[PB6] = 1'b1;
        value_override_en[PB6] = pwm1_out1_enable;
        value_override_val[PB6] = pwm1_out1_value;
        input_en_override_en[PB6] = chan7_digital_disable;
        // Interrupt pins: enable wins over the channel disable
        input_en_override_en[PB5] = chan6_digital_disable
                                    || ext_irq2_enable;
        input_en_override_val[PB5] = ext_irq2_enable;
        input_en_override_en[PB2] = chan5_digital_disable
                                    || ext_irq1_enable;
        input_en_override_val[PB2] = ext_irq1_enable;
        input_en_override_en[PB4] = amp0_digital_disable;
        input_en_override_en[PB3] = amp0_digital_disable;
        // Data pins: the receiving end is forced to input
        driver_override_en[PB1] = spi_slave;
        pullup_override_en[PB1] = spi_slave;
        pullup_override_val[PB1] = next_port_data[PB1] && !next_pud;
        value_override_en[PB1] = spi_master;
        value_override_val[PB1] = serial_mosi_out;
        driver_override_en[PB0] = spi_master;
        pullup_override_en[PB0] = spi_master;
        pullup_override_val[PB0] = next_port_data[PB0] && !next_pud;
        value_override_en[PB0] = spi_slave;
        value_override_val[PB0] = serial_miso_out;
        // Port C
        driver_override_en[PC7] = dac_output_enable;
        input_en_override_en[PC7] = dac_output_enable;
        input_en_override_en[PC6] = chan10_digital_disable;
        input_en_override_en[PC5] = chan9_digital_disable;
        input_en_override_en[PC4] = chan8_digital_disable;
        driver_override_en[PC3] = pwm2_out3_enable;
        driver_override_val[PC3] = 1'b1;
        value_override_en[PC3] = pwm2_out3_enable;
        value_override_val[PC3] = pwm2_out3_value;
        driver_override_en[PC2] = pwm2_out2_enable;
        driver_override_val[PC2] = 1'b1;
        value_override_en[PC2] = pwm2_out2_enable;
        value_override_val[PC2] = pwm2_out2_value;
        // Compare B leaves the driver to the direction bit
        value_override_en[PC1] = timer1_cmpb_out_enable;
        value_override_val[PC1] = timer1_cmpb_output;
        driver_override_en[PC0] = pwm1_out0_enable;
        driver_override_val[PC0] = 1'b1;
        value_override_en[PC0] = pwm1_out0_enable;
        value_override_val[PC0] = pwm1_out0_value;
        input_en_override_en[PC0] = ext_irq3_enable;
        input_en_override_val[PC0] = ext_irq3_enable;
    end

    // ----------------------------------------------------------------
    // Per-pin resolution
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
            logic next_drive;
            logic next_pull;
            logic next_ie;
            assign next_drive = driver_override_en[gi]
                ? driver_override_val[gi] : next_port_dir[gi];
            assign next_pull = pullup_override_en[gi]
                ? pullup_override_val[gi]
                : ({next_port_dir[gi], next_port_data[gi], next_pud}
                   == 3'b010);
            assign next_ie = input_en_override_en[gi]
                ? input_en_override_val[gi] : !mcu_sleep;
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    pin_oe_n[gi] <= RST_PIN_OE_N[gi];
                    pin_out[gi] <= RST_PIN_ZERO[gi];
                    pin_pullup_en[gi] <= RST_PIN_ZERO[gi];
                    pin_input_en[gi] <= RST_PIN_ZERO[gi];
                end else begin
                    pin_oe_n[gi] <= !next_drive;
                    // Value shows only while driving, as on a real pad
                    pin_out[gi] <= next_drive && (value_override_en[gi]
                        ? value_override_val[gi]
                        : next_port_data[gi]);
                    pin_pullup_en[gi] <= next_pull;
                    pin_input_en[gi] <= next_ie;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Pin inputs back to peripherals
    // ----------------------------------------------------------------
    // A disabled input reads as low so a floating analog pin never toggles
    // a peripheral.
    logic [PIN_COUNT-1:0] pin_digital;
    logic serial_gate;
    assign pin_digital = pin_in & pin_input_en;
    assign serial_gate = serial_pin_location_sel && !internal_reset;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            serial_clock_pin_in <= 1'b0;
            serial_master_data_in <= 1'b0;
            serial_slave_data_in <= 1'b0;
        end else begin
            serial_clock_pin_in <= pin_digital[PB7] && serial_gate;
            serial_master_data_in <= pin_digital[PB0] && serial_gate;
            serial_slave_data_in <= pin_digital[PB1] && serial_gate;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ext_irq1_input <= 1'b0;
            ext_irq2_input <= 1'b0;
            ext_irq3_input <= 1'b0;
            timer0_count_input <= 1'b0;
            timer1_count_input <= 1'b0;
            timer1_capture_b_input <= 1'b0;
            pwm1_digital_input <= 1'b0;
        end else begin
            ext_irq1_input <= pin_digital[PB2];
            ext_irq2_input <= pin_digital[PB5];
            ext_irq3_input <= pin_digital[PC0];
            timer0_count_input <= pin_digital[PC2];
            timer1_count_input <= pin_digital[PC3];
            timer1_capture_b_input <= pin_digital[PB6];
            pwm1_digital_input <= pin_digital[PC1];
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_spi_slave;
        spi_slave && !reset;
    endsequence

    sequence s_spi_master;
        spi_master && !reset;
    endsequence

    a_mosi_slave_input: assert property (
        s_spi_slave |=> pin_oe_n[PB1])
        else $error("mosi pin driven in slave mode");

    a_mosi_master_dir: assert property (
        s_spi_master |=> pin_oe_n[PB1] == !$past(next_port_dir[PB1]))
        else $error("mosi direction ignores direction bit");

    a_mosi_pullup_kept: assert property (
        s_spi_slave |=> pin_pullup_en[PB1]
            == $past(next_port_data[PB1] && !next_pud))
        else $error("mosi pull-up wrong while forced input");

    a_miso_master_input: assert property (
        s_spi_master |=> pin_oe_n[PB0]
            && pin_pullup_en[PB0] == $past(next_port_data[PB0] && !next_pud))
        else $error("miso pin not forced input in master mode");

    a_miso_slave_dir: assert property (
        s_spi_slave |=> pin_oe_n[PB0] == !$past(next_port_dir[PB0]))
        else $error("miso direction ignores direction bit");

    a_serial_in_gate: assert property (
        (!serial_pin_location_sel || internal_reset) && !reset
        |=> !serial_clock_pin_in && !serial_master_data_in
            && !serial_slave_data_in)
        else $error("serial input passes while gated");

    a_pwm23_drive: assert property (
        pwm2_out3_enable |=> !pin_oe_n[PC3]
            && pin_out[PC3] == $past(pwm2_out3_value))
        else $error("pwm2 output 3 not on its pin");

    a_irq3_input_on: assert property (
        ext_irq3_enable |=> pin_input_en[PC0] ##1
            ext_irq3_input == $past(pin_in[PC0]))
        else $error("interrupt 3 input not routed");

    a_irq2_disable_alone: assert property (
        chan6_digital_disable && !ext_irq2_enable |=> !pin_input_en[PB5]
            ##1 !ext_irq2_input)
        else $error("channel 6 disable did not cut input");

    a_dac_pin_free: assert property (
        dac_output_enable |=> pin_oe_n[PC7] && !pin_input_en[PC7])
        else $error("converter pin still driven or read");

    a_cmpb_follows_dir: assert property (
        timer1_cmpb_out_enable |=> pin_oe_n[PC1] == !$past(next_port_dir[PC1])
            && pin_out[PC1]
               == ($past(timer1_cmpb_output) && !pin_oe_n[PC1]))
        else $error("compare B pin wrong");

endmodule

// ==== testbench/pbm_board_model.sv ====
`timescale 1ns/10ps
module pbm_board_model (
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe_n,
    input wire logic [15:0] pin_pullup_en,
    input wire logic [15:0] board_drive,
    input wire logic [15:0] board_float,
    output logic [15:0] pin_in
);
    // ----------------------------------------------------------------
    // Pad level
    // ----------------------------------------------------------------
    // A floating pad without pull-up shows the inverse of the board
    // value, so a stale or guessed level never passes for a real one
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (board_float[i]) begin
                pin_in[i] = pin_pullup_en[i] | ~board_drive[i];
            end else begin
                pin_in[i] = board_drive[i];
            end
        end
    end
endmodule

// ==== testbench/port_b_c_alternate_function_mux_tb.sv ====
`timescale 1ns/10ps
module port_b_c_alternate_function_mux_tb;
    import pbm_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] c = 32'h0000_0000;
    logic [15:0] bd = 16'h0000;
    logic [15:0] bf = 16'h0000;
    logic [7:0] reg_rdata;
    logic [15:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_input_en;
    logic [10:0] routed;
    logic [15:0] rs = 16'h730E;
    logic [7:0] m_dat_b, m_dir_b, m_dat_c, m_dir_c;
    logic m_pud;
    logic [15:0] e_oe_n, e_out, e_pu, e_ie, e_pin, e_q, r, r2;
    int n_errors = 0;
    int checks_done = 0;

    pbm_pin_mux DUT (.ref_clk(ref_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup_en(pin_pullup_en), .pin_input_en(pin_input_en),
        .mcu_sleep(c[30]), .internal_reset(c[31]), .serial_if_enable(c[0]),
        .serial_if_master_sel(c[1]), .serial_pin_location_sel(c[2]),
        .serial_clock_out(c[3]), .serial_mosi_out(c[4]),
        .serial_miso_out(c[5]), .pwm0_out1_enable(c[6]),
        .pwm0_out1_value(c[7]), .pwm1_out1_enable(c[8]),
        .pwm1_out1_value(c[9]), .pwm1_out0_enable(c[10]),
        .pwm1_out0_value(c[11]), .pwm2_out2_enable(c[12]),
        .pwm2_out2_value(c[13]), .pwm2_out3_enable(c[14]),
        .pwm2_out3_value(c[15]), .ext_irq1_enable(c[16]),
        .ext_irq2_enable(c[17]), .ext_irq3_enable(c[18]),
        .chan4_digital_disable(c[19]), .chan5_digital_disable(c[20]),
        .chan6_digital_disable(c[21]), .chan7_digital_disable(c[22]),
        .chan8_digital_disable(c[23]), .chan9_digital_disable(c[24]),
        .chan10_digital_disable(c[25]), .amp0_digital_disable(c[26]),
        .dac_output_enable(c[27]), .timer1_cmpb_out_enable(c[28]),
        .timer1_cmpb_output(c[29]), .serial_clock_pin_in(routed[10]),
        .serial_master_data_in(routed[9]), .serial_slave_data_in(routed[8]),
        .ext_irq1_input(routed[7]), .ext_irq2_input(routed[6]),
        .ext_irq3_input(routed[5]), .timer0_count_input(routed[4]),
        .timer1_count_input(routed[3]), .timer1_capture_b_input(routed[2]),
        .pwm1_digital_input(routed[1]), .global_pullup_disable(routed[0]));

    pbm_board_model BOARD (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup_en(pin_pullup_en), .board_drive(bd), .board_float(bf),
        .pin_in(pin_in));

    // ----------------------------------------------------------------
    // Helpers and reference model
    // ----------------------------------------------------------------
    function automatic logic [15:0] rnd();
        for (int i = 0; i < 16; i++) begin
            rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
        end
        return rs;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
    endtask

    task automatic predict();
        logic [15:0] de, dv, ve, vv, pe, ie, iv, dir, dat, drv;
        logic sl, ms;
        ms = c[0] & c[2] & c[1];
        sl = c[0] & c[2] & !c[1];
        dir = {m_dir_c, m_dir_b};
        dat = {m_dat_c, m_dat_b};
        de = {c[27], 3'b0, c[14], c[12], 1'b0, c[10], sl | c[6], c[8], 4'b0,
              sl, ms};
        dv = {4'b0, c[14], c[12], 1'b0, c[10], c[6] & !sl, c[8], 6'b0};
        ve = {4'b0, c[14], c[12], c[28], c[10], ms | c[6], c[8], 4'b0, ms, sl};
        vv = {4'b0, c[15], c[13], c[29], c[11], ms ? c[3] : c[7], c[9], 4'b0,
              c[4], c[5]};
        pe = {8'b0, sl, 5'b0, sl, ms};
        ie = {c[27], c[25], c[24], c[23], 3'b0, c[18], c[19], c[22],
              c[21] | c[17], c[26], c[26], c[20] | c[16], 2'b0};
        iv = {7'b0, c[18], 2'b0, c[17], 2'b0, c[16], 2'b0};
        drv = (de & dv) | (~de & dir);
        e_oe_n = ~drv;
        e_out = drv & ((ve & vv) | (~ve & dat));
        e_pu = (pe | ~dir) & dat & {16{!m_pud}};
        e_ie = (ie & iv) | (~ie & {16{!c[30]}});
        e_pin = (drv & e_out) | (~drv & ~bf & bd) | (~drv & bf & (e_pu | ~bd));
        e_q = e_pin & e_ie;
    endtask

    function automatic logic [7:0] reg_exp(input logic [3:0] a);
        case (a)
            REG_PORTB_DATA: return m_dat_b;
            REG_PORTB_DIR: return m_dir_b;
            REG_PORTB_PINS: return e_q[7:0];
            REG_PORTC_DATA: return m_dat_c;
            REG_PORTC_DIR: return m_dir_c;
            REG_PORTC_PINS: return e_q[15:8];
            REG_CONTROL: return {7'h00, m_pud};
            default: return 8'h00;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        #2_000_000;
        n_errors++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        check(pin_oe_n, RST_PIN_OE_N);
        check(pin_out | pin_pullup_en | pin_input_en, RST_PIN_ZERO);
        check({5'h00, routed} | {8'h00, reg_rdata}, RST_PIN_ZERO);
        @(posedge ref_clk);
        reset <= 1'b0;
        for (int k = 0; k < 200; k++) begin
            r = rnd();
            r2 = rnd();
            m_dat_b = r[7:0];
            m_dir_b = r[15:8];
            // Comparator pin kept input without pull-up
            m_dat_c = r2[7:0] & 8'hBF;
            m_dir_c = r2[15:8] & 8'hBF;
            m_pud = r[0] & r[9];
            wr(REG_PORTB_DATA, m_dat_b);
            wr(REG_PORTB_DIR, m_dir_b);
            wr(REG_PORTC_DATA, m_dat_c);
            wr(REG_PORTC_DIR, m_dir_c);
            wr(REG_CONTROL, {7'h00, m_pud});
            wr(REG_PORTB_PINS, r2[7:0]);
            wr(4'hF, r[15:8]);
            r = rnd();
            r2 = rnd();
            @(posedge ref_clk);
            reg_write <= 1'b0;
            c <= {r, r2};
            bd <= rnd();
            bf <= rnd();
            @(posedge ref_clk);
            @(negedge ref_clk);
            predict();
            check(pin_oe_n, e_oe_n);
            check(pin_out, e_out);
            check(pin_pullup_en, e_pu);
            check(pin_input_en, e_ie);
            @(posedge ref_clk);
            @(negedge ref_clk);
            r = {5'h00, e_q[7] & c[2] & !c[31], e_q[0] & c[2] & !c[31],
                 e_q[1] & c[2] & !c[31], e_q[2], e_q[5], e_q[8], e_q[10],
                 e_q[11], e_q[6], e_q[9], m_pud};
            check({5'h00, routed}, r);
            for (int a = 0; a < 8; a++) begin
                @(posedge ref_clk);
                reg_read <= 1'b1;
                reg_addr <= a[3:0];
                @(posedge ref_clk);
                reg_read <= 1'b0;
                @(negedge ref_clk);
                check({8'h00, reg_rdata}, {8'h00, reg_exp(a[3:0])});
            end
            // Read data must drop back to zero once the answer cycle is over
            @(posedge ref_clk);
            @(negedge ref_clk);
            check({8'h00, reg_rdata}, 16'h0000);
        end
        test_done();
    end
endmodule
